// [hw/scsi_parity_control.sv]
// Parity generation, checking and observation between host bus and wide SCSI bus
`timescale 1ns/100ps
module scsi_parity_control #(
  parameter int DMA_DEPTH = scsi_parity_pkg::DMA_FIFO_DEPTH,
  parameter int SCSI_DEPTH = scsi_parity_pkg::SCSI_FIFO_DEPTH
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [7:0] scsiCtlZero, // Control byte zero image
  input wire logic [7:0] scsiCtlOne, // Control byte one image
  input wire logic [7:0] scsiIrqEnableZero, // Interrupt enable byte image
  input wire logic [7:0] scsiTestThree, // SCSI test byte three image
  input wire logic [7:0] chipTestZero, // Chip test byte zero image
  input wire logic initiatorMode, // Device acts as initiator
  input wire logic targetMode, // Device acts as target
  input wire logic sendStb, // Pulse: send one SCSI word
  input wire logic [15:0] sendData, // Host data lanes 1..0 to send
  input wire logic [3:0] hostParityPinsIn, // Host parity pins, async
  input wire scsi_parity_pkg::scsi_bus_type scsiBusIn, // SCSI data and parity pins, async
  input wire logic rcvStb, // Pulse: capture SCSI bus into input latch
  input wire logic blockMoveEnd, // Pulse: current block move finished
  input wire logic errClr, // Pulse: clear parity error flag
  input wire logic atnRelease, // Pulse: drop ATN request
  input wire logic haltRelease, // Pulse: resume after halt
  input wire logic fifoTestWrite, // Pulse: push byte through FIFO data test port
  input wire logic [7:0] fifoTestWrData, // Byte for FIFO data test port
  input wire logic fifoTestRead, // Pulse: pop byte through FIFO data test port
  input wire logic outLatchRead, // Pulse: read of SCSI output data latch
  output logic [7:0] fifoTestRdData, // Byte popped from DMA FIFO
  output scsi_parity_pkg::scsi_bus_type scsiBusOut, // Data and parity to SCSI drivers
  output logic [3:0] hostParityPinsOut, // Parity driven to host pins
  output logic [3:0] hostParityPinsOe, // Per-lane host parity drive enable
  output logic atnAssert, // SCSI ATN request
  output logic haltReq, // Halt current operation
  output logic irqReq, // Pulse: parity interrupt request
  output logic parityErrFlag, // Sticky parity error status
  output logic liveParityLow, // Live low SCSI parity line
  output logic liveParityHigh, // Live high SCSI parity line
  output logic latchParityLow, // Parity of latched low byte
  output logic latchParityHigh, // Parity of latched high byte
  output logic dmaFifoParity, // Parity of last popped DMA FIFO entry
  output logic scsiFifoParity // Parity of last popped SCSI FIFO entry
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic oddParity(input logic [7:0] b);
    oddParity = ~^b;
  endfunction

  function automatic logic oddOk(input logic [7:0] b, input logic p);
    oddOk = ^{b, p};
  endfunction

  localparam int DMA_AW = $clog2(DMA_DEPTH);
  localparam int SCSI_AW = $clog2(SCSI_DEPTH);

  scsi_parity_pkg::parity_ctl_type ctl;

  always_comb
  begin
    ctl.atnOnErr = scsiCtlZero[scsi_parity_pkg::CTL0_ATN_ON_ERR_BIT];
    ctl.parityGenEn = scsiCtlZero[scsi_parity_pkg::CTL0_PARITY_GEN_BIT];
    ctl.parityChkEn = scsiCtlZero[scsi_parity_pkg::CTL0_PARITY_CHK_BIT];
    ctl.evenSel = scsiCtlOne[scsi_parity_pkg::CTL1_EVEN_SEL_BIT];
    ctl.haltCtl = scsiCtlOne[scsi_parity_pkg::CTL1_HALT_CTL_BIT];
    ctl.parityIrqEn = scsiIrqEnableZero[scsi_parity_pkg::IRQEN0_PARITY_BIT];
    ctl.fifoPopEn = scsiTestThree[scsi_parity_pkg::TEST3_FIFO_POP_BIT];
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  scsi_parity_pkg::scsi_bus_type scsiSyncA_q;
  scsi_parity_pkg::scsi_bus_type scsiSync_q;
  logic [3:0] hostParSyncA_q;
  logic [3:0] hostParSync_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      scsiSyncA_q <= '0;
      scsiSync_q <= '0;
      hostParSyncA_q <= scsi_parity_pkg::RESET_LANES;
      hostParSync_q <= scsi_parity_pkg::RESET_LANES;
    end
    else
    begin
      scsiSyncA_q <= scsiBusIn;
      scsiSync_q <= scsiSyncA_q;
      hostParSyncA_q <= hostParityPinsIn;
      hostParSync_q <= hostParSyncA_q;
    end
  end

  // Send request is delayed two cycles so it meets the synchronised parity pins
  logic [1:0] sendPipe_q;
  logic [15:0] sendDataA_q;
  logic [15:0] sendDataB_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sendPipe_q <= 2'h0;
      sendDataA_q <= scsi_parity_pkg::RESET_WORD;
      sendDataB_q <= scsi_parity_pkg::RESET_WORD;
    end
    else
    begin
      sendPipe_q <= {sendPipe_q[0], sendStb};
      sendDataA_q <= sendData;
      sendDataB_q <= sendDataA_q;
    end
  end

  logic sendGo;
  assign sendGo = sendPipe_q[1];

  // ****************************************************************
  // Live SCSI parity lines
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      liveParityLow <= scsi_parity_pkg::RESET_BIT;
      liveParityHigh <= scsi_parity_pkg::RESET_BIT;
    end
    else
    begin
      liveParityLow <= scsiSync_q.parity[0];
      liveParityHigh <= scsiSync_q.parity[1];
    end
  end

  // ****************************************************************
  // Send path: generation or pass-through
  // ****************************************************************
  logic [1:0] genParity;
  logic [1:0] sendParity;
  logic sysErr;

  always_comb
  begin
    sysErr = 1'b0;
    for (int i = 0; i < scsi_parity_pkg::SCSI_BYTES; i++)
    begin
      genParity[i] = oddParity(sendDataB_q[8*i +: 8]);
      // Pass-through parity arrives odd from the host and is turned for even sense
      sendParity[i] = (ctl.parityGenEn ? genParity[i] : hostParSync_q[i]) ^ ctl.evenSel;
      // Only a word actually leaving is checked; idle lanes would otherwise flag forever
      if (sendGo && !oddOk(sendDataB_q[8*i +: 8], hostParSync_q[i]))
      begin
        sysErr = ctl.parityChkEn && !ctl.parityGenEn;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      scsiBusOut <= '0;
    end
    else if (sendGo)
    begin
      scsiBusOut.data <= sendDataB_q;
      scsiBusOut.parity <= sendParity;
    end
  end

  // ****************************************************************
  // Receive path: input latch and check
  // ****************************************************************
  logic [1:0] rcvParOdd;
  logic scsiErr;

  always_comb
  begin
    scsiErr = 1'b0;
    for (int i = 0; i < scsi_parity_pkg::SCSI_BYTES; i++)
    begin
      // Strip the sense so that the check itself is always odd
      rcvParOdd[i] = scsiSync_q.parity[i] ^ ctl.evenSel;
      if (rcvStb && !oddOk(scsiSync_q.data[8*i +: 8], rcvParOdd[i]))
      begin
        scsiErr = ctl.parityChkEn;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      latchParityLow <= scsi_parity_pkg::RESET_BIT;
      latchParityHigh <= scsi_parity_pkg::RESET_BIT;
    end
    else if (rcvStb)
    begin
      latchParityLow <= scsiSync_q.parity[0];
      latchParityHigh <= scsiSync_q.parity[1];
    end
  end

  // Host pins are driven only after a receive, and only in pass-through
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      hostParityPinsOut <= scsi_parity_pkg::RESET_LANES;
      hostParityPinsOe <= scsi_parity_pkg::RESET_LANES;
    end
    else if (rcvStb)
    begin
      hostParityPinsOut <= {2'h0, rcvParOdd};
      hostParityPinsOe <= ctl.parityGenEn ? 4'h0 : 4'h3;
    end
    else if (sendStb)
    begin
      hostParityPinsOe <= 4'h0;
    end
  end

  // ****************************************************************
  // Error responses
  // ****************************************************************
  logic anyErr;
  logic irqPend_q;

  assign anyErr = scsiErr || sysErr;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      parityErrFlag <= scsi_parity_pkg::RESET_BIT;
    end
    else if (anyErr)
    begin
      parityErrFlag <= 1'b1;
    end
    else if (errClr)
    begin
      parityErrFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      atnAssert <= scsi_parity_pkg::RESET_BIT;
    end
    else if (anyErr && ctl.atnOnErr && initiatorMode)
    begin
      atnAssert <= 1'b1;
    end
    else if (atnRelease)
    begin
      atnAssert <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      haltReq <= scsi_parity_pkg::RESET_BIT;
    end
    else if (anyErr && ctl.haltCtl && targetMode)
    begin
      haltReq <= 1'b1;
    end
    else if (haltRelease)
    begin
      haltReq <= 1'b0;
    end
  end

  // Initiator errors are held until the block move ends so software sees one interrupt
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      irqPend_q <= scsi_parity_pkg::RESET_BIT;
      irqReq <= scsi_parity_pkg::RESET_BIT;
    end
    else
    begin
      irqReq <= 1'b0;
      if (blockMoveEnd && (irqPend_q || (anyErr && ctl.parityIrqEn && !targetMode)))
      begin
        irqPend_q <= 1'b0;
        irqReq <= 1'b1;
      end
      else if (anyErr && ctl.parityIrqEn)
      begin
        if (targetMode)
        begin
          irqReq <= 1'b1;
        end
        else
        begin
          irqPend_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // DMA FIFO test access
  // ****************************************************************
  scsi_parity_pkg::fifo_entry_type dmaMem [DMA_DEPTH];
  logic [DMA_AW-1:0] dmaWr_q;
  logic [DMA_AW-1:0] dmaRd_q;
  logic [DMA_AW:0] dmaCnt_q;
  logic dmaPush;
  logic dmaPop;

  assign dmaPush = fifoTestWrite && (dmaCnt_q != (DMA_AW+1)'(DMA_DEPTH));
  assign dmaPop = fifoTestRead && (dmaCnt_q != '0);

  always_ff @(posedge clk)
  begin
    if (dmaPush)
    begin
      dmaMem[dmaWr_q] <= {fifoTestWrData, chipTestZero[scsi_parity_pkg::TEST0_FIFO_PAR_BIT]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      dmaWr_q <= '0;
      dmaRd_q <= '0;
      dmaCnt_q <= '0;
      fifoTestRdData <= 8'h00;
      dmaFifoParity <= scsi_parity_pkg::RESET_BIT;
    end
    else
    begin
      if (dmaPush)
      begin
        dmaWr_q <= (dmaWr_q == DMA_AW'(DMA_DEPTH - 1)) ? '0 : dmaWr_q + 1'b1;
      end
      if (dmaPop)
      begin
        dmaRd_q <= (dmaRd_q == DMA_AW'(DMA_DEPTH - 1)) ? '0 : dmaRd_q + 1'b1;
        fifoTestRdData <= dmaMem[dmaRd_q].data;
        dmaFifoParity <= dmaMem[dmaRd_q].parity;
      end
      dmaCnt_q <= dmaCnt_q + (DMA_AW+1)'(dmaPush) - (DMA_AW+1)'(dmaPop);
    end
  end

  // ****************************************************************
  // SCSI FIFO: filled by received low bytes, popped by output latch reads
  // ****************************************************************
  scsi_parity_pkg::fifo_entry_type scsiMem [SCSI_DEPTH];
  logic [SCSI_AW-1:0] scsiWr_q;
  logic [SCSI_AW-1:0] scsiRd_q;
  logic [SCSI_AW:0] scsiCnt_q;
  logic scsiPush;
  logic scsiPop;

  // A full FIFO drops new bytes; only output latch reads with pop enable set drain it here
  assign scsiPush = rcvStb && (scsiCnt_q != (SCSI_AW+1)'(SCSI_DEPTH));
  assign scsiPop = outLatchRead && ctl.fifoPopEn && (scsiCnt_q != '0);

  always_ff @(posedge clk)
  begin
    if (scsiPush)
    begin
      scsiMem[scsiWr_q] <= {scsiSync_q.data[7:0], scsiSync_q.parity[0]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      scsiWr_q <= '0;
      scsiRd_q <= '0;
      scsiCnt_q <= '0;
      scsiFifoParity <= scsi_parity_pkg::RESET_BIT;
    end
    else
    begin
      if (scsiPush)
      begin
        scsiWr_q <= (scsiWr_q == SCSI_AW'(SCSI_DEPTH - 1)) ? '0 : scsiWr_q + 1'b1;
      end
      if (scsiPop)
      begin
        scsiRd_q <= (scsiRd_q == SCSI_AW'(SCSI_DEPTH - 1)) ? '0 : scsiRd_q + 1'b1;
        scsiFifoParity <= scsiMem[scsiRd_q].parity;
      end
      scsiCnt_q <= scsiCnt_q + (SCSI_AW+1)'(scsiPush) - (SCSI_AW+1)'(scsiPop);
    end
  end

endmodule

// [hw/scsi_parity_pkg.sv]
// Constants and types for the SCSI parity control block
// Function
// - Initiator with ATN-on-error set raises ATN when a parity error is found.
// - Generation enable picks own SCSI parity or host-pin parity pass-through.
// - Check enable turns error detection on; clear means no error is flagged.
// - Even-select bit gives even sent SCSI parity when set, odd when clear.
// - Target with halt control set halts current operation on a parity error.
// - Parity interrupt enable gates whether a parity error raises an interrupt.
// - Parity error status flag sets on SCSI or system bus parity errors.
// - Two status bits follow live low and high SCSI parity lines.
// - Two status bits hold parity of bytes captured in the input latch.
// - DMA FIFO parity status shows parity of entry popped by test read.
// - Write-only parity bit is pushed with data written by test write.
// - With pop enable, output latch read pops SCSI FIFO; its parity shown.
// - Generation off: host pin parity to SCSI on send, SCSI parity to pins.
// - Generation on: pins ignored, own parity sent, pins not driven on receive.
// - Check on, generation off: check received SCSI and sent system data.
// - Check and generation on: check only received SCSI data.
// - Halt and interrupt need checking; initiator interrupts wait for block end.
// - Halt without interrupt when only halt set; neither when both clear.
package scsi_parity_pkg;

  // ****************************************************************
  // Control bit positions
  // ****************************************************************
  localparam int CTL0_ATN_ON_ERR_BIT = 1;
  localparam int CTL0_PARITY_GEN_BIT = 2;
  localparam int CTL0_PARITY_CHK_BIT = 3;
  localparam int CTL1_EVEN_SEL_BIT = 2;
  localparam int CTL1_HALT_CTL_BIT = 5;
  localparam int IRQEN0_PARITY_BIT = 0;
  localparam int TEST3_FIFO_POP_BIT = 0;
  localparam int TEST0_FIFO_PAR_BIT = 3;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int SCSI_BYTES = 2;
  localparam int HOST_LANES = 4;
  localparam int DMA_FIFO_DEPTH = 16;
  localparam int SCSI_FIFO_DEPTH = 8;
  localparam logic RESET_BIT = 1'h0;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [1:0] RESET_PAR = 2'h0;
  localparam logic [3:0] RESET_LANES = 4'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [15:0] data;
    logic [1:0] parity;
  } scsi_bus_type;

  typedef struct packed {
    logic atnOnErr;
    logic parityGenEn;
    logic parityChkEn;
    logic evenSel;
    logic haltCtl;
    logic parityIrqEn;
    logic fifoPopEn;
  } parity_ctl_type;

  typedef struct packed {
    logic [7:0] data;
    logic parity;
  } fifo_entry_type;

endpackage

// [test/scsi_far_end.sv]
// Behavioural SCSI device driving the wide bus
`timescale 1ns/100ps
module scsi_far_end (
  input wire logic clk, // Clock
  input wire logic drive, // Device drives bus
  input wire logic [15:0] word, // Word to send
  input wire logic [1:0] badPar, // Lanes sent with bad parity
  input wire logic evenSel, // Even sense
  output scsi_parity_pkg::scsi_bus_type busOut // Bus lines
);
  initial busOut = '0;
  // A released bus has no level: show a pattern that changes every cycle
  always @(posedge clk)
    if (drive)
      busOut <= {word, {~^word[15:8], ~^word[7:0]} ^ {2{evenSel}} ^ badPar};
    else
      busOut <= ~busOut;
endmodule

// [test/scsi_parity_control_asserts.sv]
// Port-level checks for the SCSI parity control block
`timescale 1ns/100ps
module scsi_parity_control_chk (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, low
  input wire logic [7:0] scsiCtlZero, // Control zero
  input wire logic [7:0] scsiCtlOne, // Control one
  input wire logic [7:0] scsiIrqEnableZero, // Irq enable
  input wire logic initiatorMode, // Initiator
  input wire logic targetMode, // Target
  input wire logic sendStb, // Send pulse
  input wire logic [15:0] sendData, // Send data
  input wire logic [3:0] hostParityPinsIn, // Host pins in
  input wire scsi_parity_pkg::scsi_bus_type scsiBusIn, // SCSI pins
  input wire logic rcvStb, // Receive pulse
  input wire logic blockMoveEnd, // Block end
  input wire scsi_parity_pkg::scsi_bus_type scsiBusOut, // Sent word
  input wire logic [3:0] hostParityPinsOe, // Host enables
  input wire logic atnAssert, // ATN
  input wire logic haltReq, // Halt
  input wire logic irqReq, // Irq pulse
  input wire logic parityErrFlag, // Error flag
  input wire logic liveParityLow, // Live low
  input wire logic liveParityHigh // Live high
);
  logic [2:0] upCnt_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Keeps $past from looking back into a reset
  always_ff @(posedge clk)
    if (!resetn)
      upCnt_q <= 3'h0;
    else if (upCnt_q != 3'h4)
      upCnt_q <= upCnt_q + 3'h1;

  property p_sendPar;
    $past(sendStb, 3) && upCnt_q == 3'h4 |-> scsiBusOut.data == $past(sendData, 3) &&
      scsiBusOut.parity == ({2{$past(scsiCtlOne[2])}} ^ ($past(scsiCtlZero[2]) ?
      {~^$past(sendData[15:8], 3), ~^$past(sendData[7:0], 3)} : $past(hostParityPinsIn[1:0], 3)));
  endproperty
  a_sendPar: assert property (p_sendPar) else $error("sent parity wrong");
  property p_rcvOe;
    rcvStb && !sendStb |=> hostParityPinsOe == ($past(scsiCtlZero[2]) ? 4'h0 : 4'h3);
  endproperty
  a_rcvOe: assert property (p_rcvOe) else $error("host pin enable wrong");
  property p_live;
    upCnt_q == 3'h4 |-> {liveParityHigh, liveParityLow} == $past(scsiBusIn.parity, 3);
  endproperty
  a_live: assert property (p_live) else $error("live parity wrong");
  property p_noChk;
    $rose(parityErrFlag) |-> $past(scsiCtlZero[3]);
  endproperty
  a_noChk: assert property (p_noChk) else $error("error without checking");
  property p_atn;
    $rose(parityErrFlag) && $past(scsiCtlZero[1]) && $past(initiatorMode) |-> atnAssert;
  endproperty
  a_atn: assert property (p_atn) else $error("no ATN on error");
  property p_halt;
    $rose(haltReq) |-> $past(targetMode) && $past(scsiCtlOne[5]) && $past(scsiCtlZero[3]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt without cause");
  property p_irqGate;
    irqReq |-> $past(scsiIrqEnableZero[0]) && $past(scsiCtlZero[3]);
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("irq while gated");
  property p_irqDefer;
    irqReq && !$past(targetMode) |-> $past(blockMoveEnd) || $past(blockMoveEnd, 2);
  endproperty
  a_irqDefer: assert property (p_irqDefer) else $error("irq before block end");

  c_irq: cover property (irqReq);
  c_halt: cover property ($rose(haltReq));
  c_atn: cover property ($rose(atnAssert));
endmodule

bind scsi_parity_control scsi_parity_control_chk u_chk (.clk, .resetn, .scsiCtlZero, .scsiCtlOne,
  .scsiIrqEnableZero, .initiatorMode, .targetMode, .sendStb, .sendData, .hostParityPinsIn, .scsiBusIn,
  .rcvStb, .blockMoveEnd, .scsiBusOut, .hostParityPinsOe, .atnAssert, .haltReq, .irqReq, .parityErrFlag,
  .liveParityLow, .liveParityHigh);

// [test/tb_scsi_parity_control.sv]
// Self-checking bench for the SCSI parity control block
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_scsi_parity_control;
  logic clk, resetn, initiatorMode, targetMode, sendStb, rcvStb, blockMoveEnd, errClr, atnRelease;
  logic haltRelease, fifoTestWrite, fifoTestRead, outLatchRead, drive, atnAssert, haltReq, irqReq;
  logic parityErrFlag, liveParityLow, liveParityHigh, latchParityLow, latchParityHigh;
  logic dmaFifoParity, scsiFifoParity;
  logic [7:0] scsiCtlZero, scsiCtlOne, scsiIrqEnableZero, scsiTestThree, chipTestZero;
  logic [7:0] fifoTestWrData, fifoTestRdData;
  logic [15:0] sendData, word;
  logic [3:0] hostParityPinsIn, hostParityPinsOut, hostParityPinsOe;
  logic [1:0] badPar;
  scsi_parity_pkg::scsi_bus_type scsiBusIn, scsiBusOut;
  int err_total = 0;
  int n_checks = 0;
  int irqCnt = 0;

  scsi_parity_control dut (.clk, .resetn, .scsiCtlZero, .scsiCtlOne, .scsiIrqEnableZero, .scsiTestThree,
    .chipTestZero, .initiatorMode, .targetMode, .sendStb, .sendData, .hostParityPinsIn, .scsiBusIn, .rcvStb,
    .blockMoveEnd, .errClr, .atnRelease, .haltRelease, .fifoTestWrite, .fifoTestWrData, .fifoTestRead,
    .outLatchRead, .fifoTestRdData, .scsiBusOut, .hostParityPinsOut, .hostParityPinsOe, .atnAssert,
    .haltReq, .irqReq, .parityErrFlag, .liveParityLow, .liveParityHigh, .latchParityLow,
    .latchParityHigh, .dmaFifoParity, .scsiFifoParity);
  scsi_far_end far (.clk, .drive, .word, .badPar, .evenSel(scsiCtlOne[2]), .busOut(scsiBusIn));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
    if (irqReq === 1'h1)
      irqCnt++;

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Trailing cycle lets the response land before anyone looks
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
    tick(1);
  endtask

  task automatic sendWord(input logic [15:0] d, input logic [1:0] pins);
    sendData = d;
    hostParityPinsIn = {2'h0, pins};
    pulse(sendStb);
    tick(4);
    `CHK(scsiBusOut.data, d)
    `CHK(scsiBusOut.parity, (scsiCtlZero[2] ? {~^d[15:8], ~^d[7:0]} : pins) ^ {2{scsiCtlOne[2]}})
    `CHK(hostParityPinsOe, 4'h0)
  endtask

  task automatic rcvWord(input logic [15:0] d, input logic [1:0] bad);
    logic [1:0] linePar;
    word = d;
    badPar = bad;
    drive = 1'h1;
    tick(5);
    linePar = scsiBusIn.parity;
    `CHK({liveParityHigh, liveParityLow}, linePar)
    pulse(rcvStb);
    drive = 1'h0;
    `CHK({latchParityHigh, latchParityLow}, linePar)
    `CHK(hostParityPinsOe, scsiCtlZero[2] ? 4'h0 : 4'h3)
    if (!scsiCtlZero[2]) `CHK(hostParityPinsOut[1:0], linePar ^ {2{scsiCtlOne[2]}})
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop;
  end

  initial
  begin
    {resetn, initiatorMode, targetMode, sendStb, rcvStb, blockMoveEnd, errClr, atnRelease} = '0;
    {haltRelease, fifoTestWrite, fifoTestRead, outLatchRead, drive} = '0;
    {scsiCtlZero, scsiCtlOne, scsiIrqEnableZero, scsiTestThree, chipTestZero, fifoTestWrData} = '0;
    {sendData, word, hostParityPinsIn, badPar} = '0;
    tick(16);
    resetn = 1'h1;
    tick(1);
    `CHK({parityErrFlag, atnAssert, haltReq, hostParityPinsOe}, 7'h00)
    // ****************************************************************
    // FIFO test paths
    // ****************************************************************
    rcvWord(16'h0001, 2'h0);
    rcvWord(16'h0003, 2'h0);
    scsiTestThree = 8'h01;
    pulse(outLatchRead);
    `CHK(scsiFifoParity, 1'h0)
    pulse(outLatchRead);
    `CHK(scsiFifoParity, 1'h1)
    chipTestZero = 8'h08;
    fifoTestWrData = 8'h5a;
    pulse(fifoTestWrite);
    chipTestZero = 8'h00;
    fifoTestWrData = 8'h5b;
    pulse(fifoTestWrite);
    // Third pop hits an empty FIFO and must leave the last entry shown
    for (int i = 0; i < 3; i++)
    begin
      pulse(fifoTestRead);
      `CHK({fifoTestRdData, dmaFifoParity}, (i == 0) ? 9'h0b5 : 9'h0b6)
    end
    // ****************************************************************
    // Generation and sense modes, checking off
    // ****************************************************************
    for (int m = 0; m < 4; m++)
    begin
      scsiCtlZero = m[1] ? 8'h04 : 8'h00;
      scsiCtlOne = {5'h0, m[0], 2'h0};
      sendWord(16'h12f0, 2'h2);
      rcvWord(16'ha5c3, {1'h0, m[0]});
    end
    `CHK(parityErrFlag, 1'h0)
    // ****************************************************************
    // Error responses
    // ****************************************************************
    initiatorMode = 1'h1;
    scsiCtlZero = 8'h0e;
    scsiCtlOne = 8'h20;
    scsiIrqEnableZero = 8'h01;
    sendWord(16'h0000, 2'h0);
    `CHK(parityErrFlag, 1'h0)
    rcvWord(16'h0f0f, 2'h2);
    `CHK({parityErrFlag, atnAssert, haltReq}, 3'h6)
    `CHK(irqCnt, 0)
    pulse(blockMoveEnd);
    tick(2);
    `CHK(irqCnt, 1)
    pulse(errClr);
    pulse(atnRelease);
    `CHK({parityErrFlag, atnAssert}, 2'h0)
    initiatorMode = 1'h0;
    targetMode = 1'h1;
    scsiCtlZero = 8'h08;
    scsiIrqEnableZero = 8'h00;
    sendWord(16'h0000, 2'h1);
    `CHK({parityErrFlag, atnAssert, haltReq}, 3'h5)
    `CHK(irqCnt, 1)
    pulse(haltRelease);
    pulse(errClr);
    `CHK({parityErrFlag, haltReq}, 2'h0)
    scsiCtlOne = 8'h04;
    scsiIrqEnableZero = 8'h01;
    rcvWord(16'h3c01, 2'h1);
    tick(2);
    `CHK({parityErrFlag, haltReq}, 2'h2)
    `CHK(irqCnt, 2)
    scsiCtlZero = 8'h00;
    rcvWord(16'h3c01, 2'h1);
    tick(2);
    `CHK(irqCnt, 2)
    report_and_stop;
  end
endmodule
